/* acm_defs.vh */
// Register map, field positions, reset values and timing counts for the accelerometer core
`ifndef ACM_DEFS_VH
`define ACM_DEFS_VH

`define ACM_A_STATUS    8'h00
`define ACM_A_OUT_XU    8'h01
`define ACM_A_OUT_XL    8'h02
`define ACM_A_OUT_YU    8'h03
`define ACM_A_OUT_YL    8'h04
`define ACM_A_OUT_ZU    8'h05
`define ACM_A_OUT_ZL    8'h06
`define ACM_A_SYSMOD    8'h0B
`define ACM_A_INTSRC    8'h0C
`define ACM_A_ID        8'h0D
`define ACM_A_XYZCFG    8'h0E
`define ACM_A_FFCFG     8'h15
`define ACM_A_FFSRC     8'h16
`define ACM_A_FFTHS     8'h17
`define ACM_A_FFCNT     8'h18
`define ACM_A_ASLP      8'h29
`define ACM_A_CTRL1     8'h2A
`define ACM_A_CTRL2     8'h2B
`define ACM_A_CTRL3     8'h2C
`define ACM_A_CTRL4     8'h2D
`define ACM_A_CTRL5     8'h2E
`define ACM_A_OFFX      8'h2F
`define ACM_A_OFFY      8'h30
`define ACM_A_OFFZ      8'h31

`define ACM_RST_BYTE    8'h00
`define ACM_B_ACTIVE    0
`define ACM_B_FREAD     1
`define ACM_B_LNOISE    2
`define ACM_B_SLPE      2
`define ACM_B_WAKE_FF   3
`define ACM_B_IPOL      1
`define ACM_B_ELE       7
`define ACM_B_OAE       6
`define ACM_B_DBDEC     0
`define ACM_I_DRDY      0
`define ACM_I_FFMT      2
`define ACM_I_ASLP      7
`define ACM_MODS_OSR    2'b10
`define ACM_FS_2G       2'b00
`define ACM_FS_4G       2'b01
`define ACM_SYS_STBY    2'b00
`define ACM_SYS_WAKE    2'b01
`define ACM_SYS_SLEEP   2'b10

`define ACM_CLK_HZ      28'd200000000
`define ACM_BASE_HZ     28'd800
`define ACM_BASE_DIV    (`ACM_CLK_HZ / `ACM_BASE_HZ)
`define ACM_ASLP_MS     28'd320
`define ACM_ASLP_DIV    (`ACM_CLK_HZ / 28'd1000 * `ACM_ASLP_MS)
`define ACM_TRIM_WORDS  6

`endif

/* acm_trim_load.v */
// Startup fetch of per-axis gain and offset trim from trim storage
`timescale 1ns/10ps
`include "acm_defs.vh"
module acm_trim_load #(
  parameter WORDS = `ACM_TRIM_WORDS
) (
  input  wire              ref_clk,
  input  wire              sys_rst,
  output wire [2:0]        trim_addr,
  input  wire [7:0]        trim_data,
  output wire [8*WORDS-1:0] trim_vals,
  output wire              trim_done
);

  reg [2:0]         idx_r;
  reg [2:0]         cap_idx_r;
  reg               vld_r;
  reg               done_r;
  reg [8*WORDS-1:0] vals_r;

  // Storage answers one cycle after the address; each word is caught then
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      idx_r     <= 3'h0;
      cap_idx_r <= 3'h0;
      vld_r     <= 1'b0;
      done_r    <= 1'b0;
      vals_r    <= {8*WORDS{1'b0}};
    end else begin
      vld_r     <= ~done_r && (idx_r < WORDS);
      cap_idx_r <= idx_r;
      if (!done_r && idx_r < WORDS)
        idx_r <= idx_r + 3'h1;
      if (vld_r) begin
        vals_r[8*cap_idx_r +: 8] <= trim_data;
        if (cap_idx_r == WORDS - 1)
          done_r <= 1'b1;
      end
    end
  end

  assign trim_addr = idx_r;
  assign trim_vals = vals_r;
  assign trim_done = done_r;

endmodule

/* acm_core.v */
// Accelerometer digital core: power states, sample path, freefall/motion detect, auto-sleep
`timescale 1ns/10ps
`include "acm_defs.vh"
module acm_core #(
  parameter [27:0] BASE_DIV = `ACM_BASE_DIV,
  parameter [27:0] ASLP_DIV = `ACM_ASLP_DIV,
  parameter [7:0]  ID_CODE  = 8'hA5
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire        reg_seq,
  input  wire [7:0]  reg_wdata,
  output wire [7:0]  reg_rdata,
  input  wire [15:0] adc_x,
  input  wire [15:0] adc_y,
  input  wire [15:0] adc_z,
  output wire        adc_start,
  output wire        analog_en,
  output wire [2:0]  trim_addr,
  input  wire [7:0]  trim_data,
  output wire        int1,
  output wire        int2
);
  // ID_CODE value is arbitrary

  localparam [2:0] ST_STBY  = 3'b001;
  localparam [2:0] ST_WAKE  = 3'b010;
  localparam [2:0] ST_SLEEP = 3'b100;

  reg  [7:0]  ctrl1_r;
  reg  [7:0]  ctrl2_r;
  reg  [7:0]  ctrl3_r;
  reg  [7:0]  ctrl4_r;
  reg  [7:0]  ctrl5_r;
  reg  [7:0]  xyzcfg_r;
  reg  [7:0]  ffcfg_r;
  reg  [7:0]  ffths_r;
  reg  [7:0]  ffcnt_r;
  reg  [7:0]  aslp_r;
  reg  [7:0]  off_r [0:2];
  reg  [13:0] smp_r [0:2];
  reg  [7:0]  status_r;
  reg  [7:0]  ffsrc_r;
  reg  [7:0]  intsrc_r;
  reg  [2:0]  st_r;
  reg  [7:0]  ptr_r;
  reg  [7:0]  rdata_r;
  reg  [27:0] base_r;
  reg  [9:0]  mul_r;
  reg  [27:0] step_r;
  reg  [7:0]  aslp_cnt_r;
  reg  [7:0]  dbc_r;
  reg         adc_start_r;
  reg         cap_r;
  reg         analog_en_r;
  reg         int1_r;
  reg         int2_r;
  reg  [13:0] cmp_w [0:2];
  reg  [15:0] mag_w [0:2];
  reg  [13:0] out_w [0:2];
  reg  [2:0]  hi_w;
  reg  [5:0]  src_w;
  reg  [14:0] sum_t;
  reg  [7:0]  rd_w;
  wire [47:0] trim_vals;
  wire        trim_done;
  integer     i;
  integer     j;
  integer     k;

  function [7:0] next_addr;
    input [7:0] a;
    input       fr;
    begin
      if (fr && (a == `ACM_A_OUT_XU || a == `ACM_A_OUT_YU))
        next_addr = a + 8'h02;
      else if ((fr && a == `ACM_A_OUT_ZU) || a == `ACM_A_OUT_ZL)
        next_addr = `ACM_A_STATUS;
      else
        next_addr = a + 8'h01;
    end
  endfunction

  // Gain trim is (256 + g) / 256; offsets are in finest-range counts, user offset doubled
  function [13:0] comp;
    input [15:0] raw;
    input [7:0]  gn;
    input [7:0]  tof;
    input [7:0]  uof;
    input [1:0]  sh;
    reg signed [9:0]  g;
    reg signed [25:0] v;
    begin
      g = $signed({gn[7], gn[7], gn}) + 10'sd256;
      v = $signed(raw) * g;
      v = (v >>> 8) + $signed({{18{tof[7]}}, tof}) + $signed({{17{uof[7]}}, uof, 1'b0});
      v = v >>> sh;
      // Saturate rather than wrap so a hard shock never reads as the opposite sign
      if (!v[25] && v[24:13] != 12'h000)
        comp = 14'h1FFF;
      else if (v[25] && v[24:13] != 12'hFFF)
        comp = 14'h2000;
      else
        comp = v[13:0];
    end
  endfunction

  function [13:0] absv;
    input [13:0] s;
    begin
      absv = s[13] ? (14'h0000 - s) : s;
    end
  endfunction

  function [9:0] rate_mult;
    input [2:0] code;
    begin
      case (code)
        3'd0:    rate_mult = 10'd1;
        3'd1:    rate_mult = 10'd2;
        3'd2:    rate_mult = 10'd4;
        3'd3:    rate_mult = 10'd8;
        3'd4:    rate_mult = 10'd16;
        3'd5:    rate_mult = 10'd64;
        3'd6:    rate_mult = 10'd128;
        default: rate_mult = 10'd512;
      endcase
    end
  endfunction

  acm_trim_load #(
    .WORDS (`ACM_TRIM_WORDS)
  ) u_trim (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .trim_addr (trim_addr),
    .trim_data (trim_data),
    .trim_vals (trim_vals),
    .trim_done (trim_done)
  );

  wire [7:0] acc_a    = reg_seq ? ptr_r : reg_addr;
  wire       wr_en    = reg_wr;
  wire       rd_en    = reg_rd & ~reg_wr;
  wire       rd_out   = rd_en && acc_a >= `ACM_A_OUT_XU && acc_a <= `ACM_A_OUT_ZL;
  wire       rd_ffsrc = rd_en && acc_a == `ACM_A_FFSRC;
  wire       rd_sysm  = rd_en && acc_a == `ACM_A_SYSMOD;
  wire       act_go   = st_r[0] & ctrl1_r[`ACM_B_ACTIVE];
  wire       slpe     = ctrl2_r[`ACM_B_SLPE];
  wire       running  = ~st_r[0] & trim_done;
  wire [1:0] eff_fs   = ctrl1_r[`ACM_B_LNOISE] ? `ACM_FS_4G : xyzcfg_r[1:0];
  wire [1:0] sh       = (eff_fs == `ACM_FS_2G) ? 2'd0 : (eff_fs == `ACM_FS_4G) ? 2'd1 : 2'd2;

  // Sample timing: base tick at the top rate, multiplied down for slower rates
  wire [9:0] mult      = rate_mult(st_r == ST_SLEEP ? {1'b1, ctrl1_r[7:6]} : ctrl1_r[5:3]);
  wire       base_tick = (base_r == BASE_DIV - 28'd1);
  wire       mul_wrap  = (mul_r >= mult - 10'd1);
  wire       smp_tick  = running & base_tick & mul_wrap;

  always @(posedge ref_clk) begin
    if (sys_rst || !running) begin
      base_r <= 28'h0000000;
      mul_r  <= 10'h000;
    end else if (base_tick) begin
      base_r <= 28'h0000000;
      mul_r  <= mul_wrap ? 10'h000 : mul_r + 10'h001;
    end else begin
      base_r <= base_r + 28'h0000001;
    end
  end

  // Front end converts on adc_start and holds the result on the following cycle
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      adc_start_r <= 1'b0;
      cap_r       <= 1'b0;
      analog_en_r <= 1'b0;
    end else begin
      adc_start_r <= smp_tick;
      cap_r       <= adc_start_r & running;
      analog_en_r <= ~st_r[0];
    end
  end

  always @* begin
    sum_t = 15'h0000;
    src_w = 6'h00;
    hi_w  = 3'b000;
    for (i = 0; i < 3; i = i + 1) begin
      cmp_w[i] = comp(i == 0 ? adc_x : (i == 1 ? adc_y : adc_z), trim_vals[8*i +: 8],
                      trim_vals[24+8*i +: 8], off_r[i], sh);
      mag_w[i] = {2'b00, absv(cmp_w[i])} << sh;
      hi_w[i]  = mag_w[i] > {1'b0, ffths_r[6:0], 8'h00};
      sum_t    = {smp_r[i][13], smp_r[i]} + {cmp_w[i][13], cmp_w[i]};
      // Averaging trades bandwidth for noise; detectors still see raw data
      out_w[i] = (ctrl2_r[1:0] == `ACM_MODS_OSR) ? sum_t[14:1] : cmp_w[i];
      src_w[2*i+1] = ffcfg_r[3+i] & hi_w[i];
      // Direction only for axes that tripped, so idle axes never look like a cause
      src_w[2*i]   = ffcfg_r[3+i] & hi_w[i] & cmp_w[i][13];
    end
  end

  wire [2:0] en_ax  = ffcfg_r[5:3];
  wire       motion = ffcfg_r[`ACM_B_OAE];
  wire       cond   = motion ? |(en_ax & hi_w) : (en_ax != 3'b000) & ~|(en_ax & hi_w);
  wire       ff_evt = cap_r & cond & ({1'b0, dbc_r} + 9'h001 >= {1'b0, ffcnt_r});
  wire       evt_en = ff_evt & ctrl4_r[`ACM_I_FFMT];
  wire       wake_ev = evt_en & ctrl3_r[`ACM_B_WAKE_FF] & slpe;
  wire       step_tk = (step_r == ASLP_DIV - 28'd1);
  wire       to_sleep = slpe & step_tk & (aslp_cnt_r >= aslp_r);
  wire       aslp_ev = (st_r == ST_WAKE && to_sleep) || (st_r == ST_SLEEP && wake_ev);

  always @(posedge ref_clk) begin
    if (sys_rst || act_go) begin
      dbc_r <= 8'h00;
    end else if (cap_r) begin
      if (cond)
        dbc_r <= (dbc_r == 8'hFF) ? dbc_r : dbc_r + 8'h01;
      else if (ffcfg_r[`ACM_B_DBDEC] && dbc_r != 8'h00)
        dbc_r <= dbc_r - 8'h01;
      else
        dbc_r <= 8'h00;
    end
  end

  // Inactivity timer only runs in wake; an enabled freefall/motion event restarts it
  always @(posedge ref_clk) begin
    if (sys_rst || st_r != ST_WAKE || !slpe || evt_en) begin
      step_r     <= 28'h0000000;
      aslp_cnt_r <= 8'h00;
    end else if (step_tk) begin
      step_r     <= 28'h0000000;
      aslp_cnt_r <= (aslp_cnt_r == 8'hFF) ? aslp_cnt_r : aslp_cnt_r + 8'h01;
    end else begin
      step_r <= step_r + 28'h0000001;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= ST_STBY;
    end else if (!ctrl1_r[`ACM_B_ACTIVE]) begin
      st_r <= ST_STBY;
    end else begin
      case (st_r)
        ST_STBY:  st_r <= ST_WAKE;
        ST_WAKE:  if (to_sleep) st_r <= ST_SLEEP;
        ST_SLEEP: if (wake_ev || !slpe) st_r <= ST_WAKE;
        default:  st_r <= ST_STBY;
      endcase
    end
  end

  // Flags: a setting event in the same cycle as the clearing read wins
  always @(posedge ref_clk) begin
    if (sys_rst || act_go) begin
      status_r <= `ACM_RST_BYTE;
      intsrc_r <= `ACM_RST_BYTE;
      ffsrc_r  <= `ACM_RST_BYTE;
    end else begin
      if (cap_r)
        status_r <= {status_r[7:4] | status_r[3:0], 4'hF};
      else if (rd_out)
        status_r <= `ACM_RST_BYTE;
      if (cap_r)
        intsrc_r[`ACM_I_DRDY] <= 1'b1;
      else if (rd_out)
        intsrc_r[`ACM_I_DRDY] <= 1'b0;
      if (ff_evt)
        intsrc_r[`ACM_I_FFMT] <= 1'b1;
      else if (rd_ffsrc)
        intsrc_r[`ACM_I_FFMT] <= 1'b0;
      if (aslp_ev)
        intsrc_r[`ACM_I_ASLP] <= 1'b1;
      else if (rd_sysm)
        intsrc_r[`ACM_I_ASLP] <= 1'b0;
      if (ff_evt && !(ffcfg_r[`ACM_B_ELE] && ffsrc_r[7] && !rd_ffsrc))
        ffsrc_r <= {2'b10, src_w};
      else if (cap_r && !ffcfg_r[`ACM_B_ELE])
        ffsrc_r <= {2'b00, src_w};
      else if (rd_ffsrc)
        ffsrc_r <= `ACM_RST_BYTE;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      for (j = 0; j < 3; j = j + 1)
        smp_r[j] <= 14'h0000;
    end else if (cap_r) begin
      for (j = 0; j < 3; j = j + 1)
        smp_r[j] <= out_w[j];
    end
  end

  // Configuration writes; standby transitions never touch these
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl1_r  <= `ACM_RST_BYTE;
      ctrl2_r  <= `ACM_RST_BYTE;
      ctrl3_r  <= `ACM_RST_BYTE;
      ctrl4_r  <= `ACM_RST_BYTE;
      ctrl5_r  <= `ACM_RST_BYTE;
      xyzcfg_r <= `ACM_RST_BYTE;
      ffcfg_r  <= `ACM_RST_BYTE;
      ffths_r  <= `ACM_RST_BYTE;
      ffcnt_r  <= `ACM_RST_BYTE;
      aslp_r   <= `ACM_RST_BYTE;
      for (k = 0; k < 3; k = k + 1)
        off_r[k] <= `ACM_RST_BYTE;
    end else if (wr_en) begin
      case (acc_a)
        `ACM_A_CTRL1:  ctrl1_r  <= reg_wdata;
        `ACM_A_CTRL2:  ctrl2_r  <= reg_wdata;
        `ACM_A_CTRL3:  ctrl3_r  <= reg_wdata;
        `ACM_A_CTRL4:  ctrl4_r  <= reg_wdata;
        `ACM_A_CTRL5:  ctrl5_r  <= reg_wdata;
        `ACM_A_XYZCFG: xyzcfg_r <= reg_wdata;
        `ACM_A_FFCFG:  ffcfg_r  <= reg_wdata;
        `ACM_A_FFTHS:  ffths_r  <= reg_wdata;
        `ACM_A_FFCNT:  ffcnt_r  <= reg_wdata;
        `ACM_A_ASLP:   aslp_r   <= reg_wdata;
        `ACM_A_OFFX:   off_r[0] <= reg_wdata;
        `ACM_A_OFFY:   off_r[1] <= reg_wdata;
        `ACM_A_OFFZ:   off_r[2] <= reg_wdata;
        default:       ;
      endcase
    end
  end

  always @* begin
    case (acc_a)
      `ACM_A_STATUS: rd_w = status_r;
      `ACM_A_OUT_XU: rd_w = smp_r[0][13:6];
      `ACM_A_OUT_XL: rd_w = {smp_r[0][5:0], 2'b00};
      `ACM_A_OUT_YU: rd_w = smp_r[1][13:6];
      `ACM_A_OUT_YL: rd_w = {smp_r[1][5:0], 2'b00};
      `ACM_A_OUT_ZU: rd_w = smp_r[2][13:6];
      `ACM_A_OUT_ZL: rd_w = {smp_r[2][5:0], 2'b00};
      `ACM_A_SYSMOD: rd_w = {6'h00, st_r == ST_WAKE ? `ACM_SYS_WAKE :
                             (st_r == ST_SLEEP ? `ACM_SYS_SLEEP : `ACM_SYS_STBY)};
      `ACM_A_INTSRC: rd_w = intsrc_r;
      `ACM_A_ID:     rd_w = ID_CODE;
      `ACM_A_XYZCFG: rd_w = xyzcfg_r;
      `ACM_A_FFCFG:  rd_w = ffcfg_r;
      `ACM_A_FFSRC:  rd_w = ffsrc_r;
      `ACM_A_FFTHS:  rd_w = ffths_r;
      `ACM_A_FFCNT:  rd_w = ffcnt_r;
      `ACM_A_ASLP:   rd_w = aslp_r;
      `ACM_A_CTRL1:  rd_w = ctrl1_r;
      `ACM_A_CTRL2:  rd_w = ctrl2_r;
      `ACM_A_CTRL3:  rd_w = ctrl3_r;
      `ACM_A_CTRL4:  rd_w = ctrl4_r;
      `ACM_A_CTRL5:  rd_w = ctrl5_r;
      `ACM_A_OFFX:   rd_w = off_r[0];
      `ACM_A_OFFY:   rd_w = off_r[1];
      `ACM_A_OFFZ:   rd_w = off_r[2];
      default:       rd_w = 8'h00;
    endcase
  end

  // Register port and interrupt pins; access works in every power state
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
      ptr_r   <= `ACM_A_STATUS;
      int1_r  <= 1'b1;
      int2_r  <= 1'b1;
    end else begin
      if (rd_en)
        rdata_r <= rd_w;
      if (rd_en || wr_en)
        ptr_r <= next_addr(acc_a, ctrl1_r[`ACM_B_FREAD]);
      int1_r <= |(intsrc_r & ctrl4_r & ctrl5_r) ^ ~ctrl3_r[`ACM_B_IPOL];
      int2_r <= |(intsrc_r & ctrl4_r & ~ctrl5_r) ^ ~ctrl3_r[`ACM_B_IPOL];
    end
  end

  assign reg_rdata = rdata_r;
  assign adc_start = adc_start_r;
  assign analog_en = analog_en_r;
  assign int1      = int1_r;
  assign int2      = int2_r;

endmodule

/* acm_analog_model.sv */
// Behavioural analog front end and trim storage facing the accelerometer core
`timescale 1ns/10ps
module acm_analog_model (
  input  wire        ref_clk,
  input  wire        adc_start,
  input  wire [2:0]  trim_addr,
  output logic [7:0] trim_data,
  output wire [15:0] adc_x,
  output wire [15:0] adc_y,
  output wire [15:0] adc_z
);
  logic [15:0] val_x   = 16'h0100;
  logic [15:0] val_y   = 16'hFF9C;
  logic [15:0] val_z   = 16'h0100;
  logic        start_d = 1'b0;
  logic [7:0]  junk    = 8'h5A;
  logic [7:0]  junk_n;
  // Results are only held around a request; outside it the bus churns so stale data is never trusted
  wire         vld     = adc_start | start_d;
  assign junk_n = ~junk;
  assign adc_x  = vld ? val_x : {junk, junk_n};
  assign adc_y  = vld ? val_y : {junk_n, junk};
  assign adc_z  = vld ? val_z : {junk, junk};
  always @(posedge ref_clk) begin
    start_d <= adc_start;
    junk <= junk + 8'h3B;
    // Unity gain everywhere, factory offset of 4 counts on x only
    trim_data <= (trim_addr == 3'd3) ? 8'h04 : 8'h00;
  end
endmodule

/* acm_core_props.sv */
// Port-level assertions for the accelerometer core
`timescale 1ns/10ps
module acm_core_props #(
  parameter [27:0] BASE_DIV = 28'd8,
  parameter [27:0] ASLP_DIV = 28'd16,
  parameter [7:0]  ID_CODE  = 8'hA5
) (
  input wire       ref_clk,
  input wire       sys_rst,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire       reg_seq,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       adc_start,
  input wire       analog_en,
  input wire [2:0] trim_addr,
  input wire       int1,
  input wire       int2
);
  logic [7:0]  c4;
  logic [7:0]  c5;
  logic        ipol;
  logic [27:0] gap;
  wire         dwr = reg_wr && !reg_seq;
  wire  [7:0]  m1  = c4 & c5;
  wire  [7:0]  m2  = c4 & ~c5;
  // Shadows only follow direct writes; burst writes are not used on these registers
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      c4 <= 8'h00;
      c5 <= 8'h00;
      ipol <= 1'b0;
      gap <= 28'hFFFFFFF;
    end else begin
      if (dwr && reg_addr == 8'h2D) c4 <= reg_wdata;
      if (dwr && reg_addr == 8'h2E) c5 <= reg_wdata;
      if (dwr && reg_addr == 8'h2C) ipol <= reg_wdata[1];
      if (!analog_en) gap <= 28'hFFFFFFF;
      else if (adc_start) gap <= 28'd1;
      else if (gap != 28'hFFFFFFF) gap <= gap + 28'd1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_reset_values: assert property (
    $fell(sys_rst) |-> !analog_en && !adc_start && int1 && int2 && reg_rdata == 8'h00 && trim_addr == 3'd0)
    else $error("outputs not at reset level after release");
  a_trim_order: assert property (
    trim_addr == 3'd0 ##1 trim_addr == 3'd1 |=> trim_addr == 3'd2 ##1 trim_addr == 3'd3 ##1 trim_addr == 3'd4
    ##1 trim_addr == 3'd5) else $error("trim words not fetched in order");
  a_stby_idle: assert property (
    !analog_en && !$past(analog_en) |-> !adc_start) else $error("conversion requested in standby");
  a_sample_gap: assert property (
    adc_start |-> gap >= BASE_DIV) else $error("conversions closer than the base period");
  a_start_enable: assert property (
    dwr && reg_addr == 8'h2A && reg_wdata[0] |-> ##[1:4] analog_en) else $error("activation did not power up");
  a_stop_disable: assert property (
    dwr && reg_addr == 8'h2A && !reg_wdata[0] |-> ##[1:4] !analog_en) else $error("standby did not power down");
  a_id_read: assert property (
    !analog_en && reg_rd && !reg_wr && !reg_seq && reg_addr == 8'h0D |-> ##[1:2] reg_rdata == ID_CODE)
    else $error("register read failed in standby");
  a_int1_idle: assert property (
    m1 == 8'h00 && $past(m1) == 8'h00 && $past(m1, 2) == 8'h00 && $stable(ipol) && $past(ipol, 2) == ipol
    |-> int1 == !ipol) else $error("int1 active with no source routed to it");
  a_int2_idle: assert property (
    m2 == 8'h00 && $past(m2) == 8'h00 && $past(m2, 2) == 8'h00 && $stable(ipol) && $past(ipol, 2) == ipol
    |-> int2 == !ipol) else $error("int2 active with no source routed to it");
endmodule
bind acm_core acm_core_props #(.BASE_DIV(BASE_DIV), .ASLP_DIV(ASLP_DIV), .ID_CODE(ID_CODE)) u_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_seq(reg_seq), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_start(adc_start),
  .analog_en(analog_en), .trim_addr(trim_addr), .int1(int1), .int2(int2));

/* acm_core_tb_top.sv */
// Self-checking bench for the accelerometer core
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module acm_core_tb_top;
  logic        ref_clk   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        reg_seq   = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  wire  [7:0]  reg_rdata;
  wire  [15:0] adc_x;
  wire  [15:0] adc_y;
  wire  [15:0] adc_z;
  wire         adc_start;
  wire         analog_en;
  wire         int1;
  wire         int2;
  wire  [2:0]  trim_addr;
  wire  [7:0]  trim_data;
  int          miscompares = 0;
  int          checks = 0;
  int          n;
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Short divisors keep conversion and sleep timing within a few hundred cycles; 8'h3C is an arbitrary id
  acm_core #(.BASE_DIV(28'd8), .ASLP_DIV(28'd16), .ID_CODE(8'h3C)) uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_seq(reg_seq), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_x(adc_x), .adc_y(adc_y),
    .adc_z(adc_z), .adc_start(adc_start), .analog_en(analog_en), .trim_addr(trim_addr),
    .trim_data(trim_data), .int1(int1), .int2(int2));
  acm_analog_model afe (
    .ref_clk(ref_clk), .adc_start(adc_start), .trim_addr(trim_addr), .trim_data(trim_data),
    .adc_x(adc_x), .adc_y(adc_y), .adc_z(adc_z));
  task automatic summarize;
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_seq <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic s, input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_seq <= s;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input logic s, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(s, a, d);
    `CHK(d, e)
  endtask
  task automatic axis(input logic [7:0] a, input logic [13:0] v);
    rdc(1'b0, a, v[13:6]);
    rdc(1'b0, a + 8'h01, {v[5:0], 2'b00});
  endtask
  // Waits for k conversion requests, then lets the results land
  task automatic smp(input int k);
    repeat (k) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        #1 n++;
      end while (adc_start !== 1'b1 && n < 5000);
      if (n >= 5000) begin
        `CHK(1'b0, 1'b1)
        summarize();
      end
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic poll(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    n = 0;
    do begin
      rd(1'b0, a, d);
      n++;
    end while (d !== e && n < 400);
    `CHK(d, e)
    if (d !== e) summarize();
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (12) @(posedge ref_clk);
    for (int a = 8'h29; a <= 8'h31; a++) rdc(1'b0, a[7:0], 8'h00);
    rdc(1'b0, 8'h0D, 8'h3C);
    rdc(1'b0, 8'h07, 8'h00);
    wr(8'h0D, 8'hFF);
    rdc(1'b0, 8'h0D, 8'h3C);
    repeat (40) @(posedge ref_clk);
    rdc(1'b0, 8'h00, 8'h00);
    wr(8'h2F, 8'h03);
    wr(8'h2D, 8'h04);
    wr(8'h2E, 8'h04);
    wr(8'h15, 8'hC8);
    wr(8'h17, 8'h02);
    wr(8'h18, 8'h03);
    wr(8'h2A, 8'h01);
    rdc(1'b0, 8'h0B, 8'h01);
    smp(1);
    axis(8'h01, 14'h010A);
    axis(8'h03, 14'h3F9C);
    axis(8'h05, 14'h0100);
    wr(8'h2A, 8'h03);
    rdc(1'b0, 8'h01, 8'h04);
    rdc(1'b1, 8'h00, 8'hFE);
    rdc(1'b1, 8'h00, 8'h04);
    wr(8'h2A, 8'h01);
    rdc(1'b0, 8'h01, 8'h04);
    rdc(1'b1, 8'h00, 8'h28);
    wr(8'h2B, 8'h02);
    smp(1);
    afe.val_z <= 16'h0300;
    smp(1);
    rdc(1'b0, 8'h05, 8'h08);
    wr(8'h2B, 8'h00);
    afe.val_z <= 16'h0100;
    smp(1);
    wr(8'h0E, 8'h02);
    smp(1);
    axis(8'h03, 14'h3FE7);
    rdc(1'b0, 8'h05, 8'h01);
    wr(8'h0E, 8'h00);
    wr(8'h2A, 8'h05);
    smp(1);
    axis(8'h03, 14'h3FCE);
    axis(8'h05, 14'h0080);
    wr(8'h2A, 8'h01);
    afe.val_x <= 16'h0400;
    smp(2);
    `CHK(int1, 1'b1)
    afe.val_x <= 16'h0100;
    smp(1);
    afe.val_x <= 16'h0400;
    smp(2);
    `CHK(int1, 1'b1)
    smp(1);
    `CHK(int1, 1'b0)
    `CHK(int2, 1'b1)
    afe.val_x <= 16'h0100;
    rdc(1'b0, 8'h16, 8'h82);
    repeat (2) @(posedge ref_clk);
    `CHK(int1, 1'b1)
    wr(8'h29, 8'h02);
    wr(8'h2C, 8'h08);
    wr(8'h2B, 8'h04);
    poll(8'h0B, 8'h02);
    afe.val_x <= 16'h0400;
    poll(8'h0B, 8'h01);
    afe.val_x <= 16'h0100;
    wr(8'h2A, 8'h00);
    rdc(1'b0, 8'h2F, 8'h03);
    rdc(1'b0, 8'h0B, 8'h00);
    `CHK(int1, 1'b0)
    wr(8'h2A, 8'h01);
    repeat (3) @(posedge ref_clk);
    `CHK(int1, 1'b1)
    rdc(1'b0, 8'h16, 8'h00);
    rdc(1'b0, 8'h2F, 8'h03);
    wr(8'h15, 8'h88);
    smp(4);
    `CHK(int1, 1'b0)
    rdc(1'b0, 8'h16, 8'h80);
    summarize();
  end
endmodule
